/* File: hw/agcr_global_config.v */
// converter global configuration register with axi4-lite access
`timescale 1ns/1ps
`include "agcr_consts.vh"
module agcr_global_config (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         offsetTrimEnable,
  output reg         gainTrimEnable,
  output reg  [1:0]  idleToneSpreadLevel,
  output reg  [1:0]  biasCurrentScale,
  output reg  [7:0]  referenceTempcoTrim,
  output reg         analogClockTick,
  output reg         dataReadyPulse
);
  reg  [23:0] cfg_q;
  reg  [23:0] cfg_d;
  reg  [7:0]  awAddr_q;
  reg         awHeld_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;
  reg         wHeld_q;
  reg  [23:0] delayLine_q;
  wire        analogTick;
  wire        outputTick;
  wire        doWrite;
  wire        delayedReady;
  integer     i;

  // ------------------------------------------------------------
  // write channel: address and data caught in either order
  // ------------------------------------------------------------
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign doWrite       = awHeld_q && wHeld_q;

  always @(posedge clock) begin
    if (rst) begin
      awAddr_q     <= 8'h00;
      awHeld_q     <= 1'b0;
      wData_q      <= 32'h00000000;
      wStrb_q      <= 4'h0;
      wHeld_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AGCR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ({2'b00, awAddr_q[7:2]} == `AGCR_CFG_INDEX) ? `AGCR_RESP_OKAY : `AGCR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  // byte lanes 0..2 hold the 24 bits; lane 3 has nothing behind it
  always @* begin
    cfg_d = cfg_q;
    if (doWrite && {2'b00, awAddr_q[7:2]} == `AGCR_CFG_INDEX) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (wStrb_q[i]) begin
          cfg_d[i*8 +: 8] = wData_q[i*8 +: 8];
        end
      end
    end
    cfg_d = cfg_d & `AGCR_CFG_WMASK; // [R7]
  end

  always @(posedge clock) begin
    if (rst) begin
      cfg_q <= `AGCR_CFG_RESET; // [R9]
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ------------------------------------------------------------
  // read channel: one cycle to answer
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AGCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if ({2'b00, s_axi_araddr[7:2]} == `AGCR_CFG_INDEX) begin
        s_axi_rdata <= {8'h00, cfg_q}; // [R7]
        s_axi_rresp <= `AGCR_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `AGCR_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // clock derivation and data-ready timing
  // ------------------------------------------------------------
  agcr_clock_divider u_div (
    .clock       (clock),
    .rst         (rst),
    .prescaleSel (cfg_q[`AGCR_PRE_HI:`AGCR_PRE_LO]),
    .osrSel      (cfg_q[`AGCR_OSR_HI:`AGCR_OSR_LO]),
    .analogTick  (analogTick),
    .outputTick  (outputTick)
  );

  // the system clock stands for the digital master clock, so the delay is 24 cycles
  always @(posedge clock) begin
    if (rst) begin
      delayLine_q <= 24'h000000;
    end else begin
      delayLine_q <= {delayLine_q[22:0], outputTick}; // [R2]
    end
  end
  assign delayedReady = delayLine_q[`AGCR_GAIN_DELAY-1];

  // ------------------------------------------------------------
  // field outputs
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      offsetTrimEnable    <= 1'b0;
      gainTrimEnable      <= 1'b0;
      idleToneSpreadLevel <= 2'h3;
      biasCurrentScale    <= 2'h2;
      referenceTempcoTrim <= 8'h50;
      analogClockTick     <= 1'b0;
      dataReadyPulse      <= 1'b0;
    end else begin
      offsetTrimEnable    <= cfg_q[`AGCR_OFFEN_BIT]; // [R1]
      gainTrimEnable      <= cfg_q[`AGCR_GAINEN_BIT]; // [R2]
      idleToneSpreadLevel <= cfg_q[`AGCR_DITH_HI:`AGCR_DITH_LO]; // [R3]
      biasCurrentScale    <= cfg_q[`AGCR_BIAS_HI:`AGCR_BIAS_LO]; // [R4]
      referenceTempcoTrim <= cfg_q[`AGCR_TRIM_HI:`AGCR_TRIM_LO]; // [R8]
      analogClockTick     <= analogTick; // [R5]
      // offset trim adds no delay; only gain trim selects the delayed pulse
      dataReadyPulse      <= cfg_q[`AGCR_GAINEN_BIT] ? delayedReady : outputTick; // [R2]
    end
  end
endmodule

/* File: shared/agcr_consts.vh */
// constants for the converter global configuration register block
// ------------------------------------------------------------
// Functional notes
// [R1] offset trim enable turns on offset correction for all channels with no added delay, off by default.
// [R2] gain trim enable turns on gain correction and delays every data-ready pulse by 24 digital clock periods.
// [R3] the dither field selects max (11, default), medium (10), minimum (01) or off (00).
// [R4] the bias field selects twice (11), nominal (10, default), 0.66 times (01) or half (00) bias current.
// [R5] the prescaler field divides the master clock by 1 (00, default), 2, 4 or 8 to make the analog clock.
// [R6] the oversampling field picks ratios 32 to 4096, default 256, sampling at the analog clock rate.
// [R7] bits 12 to 8 read as zero and ignore writes.
// [R8] the low byte holds the reference tempco trim, passed straight to the reference, reset to 0x50.
// [R9] after reset the whole register reads 0x386050.
// ------------------------------------------------------------
`ifndef AGCR_CONSTS_VH
`define AGCR_CONSTS_VH

`define AGCR_CFG_INDEX      8'h0d
`define AGCR_CFG_ADDR       8'h34
`define AGCR_CFG_RESET      24'h386050
`define AGCR_CFG_WMASK      24'hffe0ff
`define AGCR_OFFEN_BIT      23
`define AGCR_GAINEN_BIT     22
`define AGCR_DITH_HI        21
`define AGCR_DITH_LO        20
`define AGCR_BIAS_HI        19
`define AGCR_BIAS_LO        18
`define AGCR_PRE_HI         17
`define AGCR_PRE_LO         16
`define AGCR_OSR_HI         15
`define AGCR_OSR_LO         13
`define AGCR_TRIM_HI        7
`define AGCR_TRIM_LO        0
`define AGCR_GAIN_DELAY     24
`define AGCR_RESP_OKAY      2'h0
`define AGCR_RESP_SLVERR    2'h2

`endif

/* File: hw/agcr_clock_divider.v */
// analog clock enable and output-rate enable divider
`timescale 1ns/1ps
module agcr_clock_divider (
  input  wire        clock,
  input  wire        rst,
  input  wire [1:0]  prescaleSel,
  input  wire [2:0]  osrSel,
  output reg         analogTick,
  output reg         outputTick
);
  reg  [2:0]  preCnt_q;
  reg  [11:0] osrCnt_q;
  wire [2:0]  preLast;
  wire [11:0] osrLast;

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  assign preLast = (3'h1 << prescaleSel) - 3'h1; // [R5]
  assign osrLast = (12'h020 << osrSel) - 12'h001; // [R6]

  // a setting change restarts no count; the new limit applies at once, and a count already past it wraps on its next step
  always @(posedge clock) begin
    if (rst) begin
      preCnt_q   <= 3'h0;
      osrCnt_q   <= 12'h000;
      analogTick <= 1'b0;
      outputTick <= 1'b0;
    end else begin
      analogTick <= 1'b0;
      outputTick <= 1'b0;
      if (preCnt_q >= preLast) begin
        preCnt_q   <= 3'h0;
        analogTick <= 1'b1; // [R5]
        if (osrCnt_q >= osrLast) begin
          osrCnt_q   <= 12'h000;
          outputTick <= 1'b1; // [R6]
        end else begin
          osrCnt_q <= osrCnt_q + 12'h001;
        end
      end else begin
        preCnt_q <= preCnt_q + 3'h1;
      end
    end
  end
endmodule

/* File: verification/agcr_global_config_chk.sv */
// assertion checker for the global configuration register ports
`timescale 1ns/1ps
module agcr_global_config_chk (
  input wire        clock,
  input wire        rst,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        offsetTrimEnable,
  input wire        gainTrimEnable,
  input wire [1:0]  idleToneSpreadLevel,
  input wire [1:0]  biasCurrentScale,
  input wire [7:0]  referenceTempcoTrim,
  input wire        dataReadyPulse
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  wire [13:0] fieldsOut = {offsetTrimEnable, gainTrimEnable, idleToneSpreadLevel, biasCurrentScale, referenceTempcoTrim};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  rst_defaults_a: assert property ($fell(rst) |-> fieldsOut == 14'h0e50) else $error("fields off default");
  rd_reserved_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00 && s_axi_rdata[12:8] == 5'h00)
    else $error("reserved bits read nonzero");
  // a gain toggle may pull one pulse 24 clocks early, so only a short gap is safe
  drdy_gap_a: assert property (dataReadyPulse |=> !dataReadyPulse [*4]) else $error("data ready too close");
  cfg_stable_a: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(fieldsOut))
    else $error("fields moved without write");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while busy");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("wready while busy");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (dataReadyPulse);
endmodule
bind agcr_global_config agcr_global_config_chk chk (.*);

/* File: verification/tb_adc_global_config_register.sv */
// self-checking bench for the global configuration register
`timescale 1ns/1ps
`include "agcr_consts.vh"
module tb_adc_global_config_register;
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  logic        clock, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0]  s_axi_wstrb = 0, s;
  logic [1:0]  pre;
  logic [23:0] cfg_q;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, analogClockTick, dataReadyPulse;
  wire         offsetTrimEnable, gainTrimEnable;
  wire [1:0]   s_axi_bresp, s_axi_rresp, idleToneSpreadLevel, biasCurrentScale;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   referenceTempcoTrim;
  int          n_mismatch = 0, total_checks = 0, k, t, cyc = 0;
  always @(posedge clock) cyc <= cyc + 1;
  agcr_global_config dut (.*);
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task guard(inout int n, input int lim);
    if (++n > lim) begin
      n_mismatch++;
      close_out;
    end
  endtask
  // readies are looked at on the falling edge, so the rising edge never races the design
  task wr(input [7:0] a, input [31:0] v, input [3:0] st, input [1:0] r);
    logic aw, w, b;
    int n;
    aw = 1; w = 1; b = 1; n = 0;
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= st;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (b) begin
      @(negedge clock);
      if (aw && s_axi_awready) aw = 0;
      if (w && s_axi_wready) w = 0;
      if (s_axi_bvalid) begin
        b = 0;
        chk("bresp", s_axi_bresp, r);
      end
      @(posedge clock);
      s_axi_awvalid <= aw; s_axi_wvalid <= w; s_axi_bready <= b;
      guard(n, 40);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] r);
    logic ar, rv;
    int n;
    ar = 1; rv = 1; n = 0;
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (rv) begin
      @(negedge clock);
      if (ar && s_axi_arready) ar = 0;
      if (s_axi_rvalid) begin
        rv = 0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", s_axi_rresp, r);
      end
      @(posedge clock);
      s_axi_arvalid <= ar; s_axi_rready <= rv;
      guard(n, 40);
    end
  endtask
  function logic [23:0] merge(logic [23:0] o, logic [31:0] v, logic [3:0] st);
    merge = o;
    for (int j = 0; j < 3; j++) if (st[j]) merge[j*8+:8] = v[j*8+:8];
    merge = merge & `AGCR_CFG_WMASK;
  endfunction
  task fields;
    repeat (2) @(negedge clock);
    chk("fields", {offsetTrimEnable, gainTrimEnable, idleToneSpreadLevel, biasCurrentScale, referenceTempcoTrim},
        {cfg_q[23:18], cfg_q[7:0]});
  endtask
  // the first pulses may still run at the old setting, so the gap between the third and fourth pulses is measured
  task per(input bit dr, input int e);
    int n, c, g;
    n = 0; c = 0; g = 0;
    while (n < 4) begin
      @(negedge clock);
      if (dr ? dataReadyPulse : analogClockTick) n++;
      else if (n == 3) c++;
      guard(g, 40000);
    end
    chk(dr ? "drdy" : "tick", c + 1, e);
  endtask
  // phase of the data-ready pulse within a 32-clock output period, after old-setting pulses drain
  task phase(output int p);
    int n, g;
    n = 0; g = 0;
    while (n < 3) begin
      @(negedge clock);
      if (dataReadyPulse) n++;
      guard(g, 400);
    end
    p = cyc % 32;
  endtask
  initial begin
    t = $urandom(98216);
    repeat (4) @(posedge clock);
    rst <= 0;
    cfg_q = `AGCR_CFG_RESET;
    rd(`AGCR_CFG_ADDR, cfg_q, `AGCR_RESP_OKAY);
    fields;
    wr(`AGCR_CFG_ADDR, 32'hffffffff, 4'hf, `AGCR_RESP_OKAY);
    cfg_q = merge(cfg_q, 32'hffffffff, 4'hf);
    rd(`AGCR_CFG_ADDR, cfg_q, `AGCR_RESP_OKAY);
    wr(8'h30, 32'h0, 4'hf, `AGCR_RESP_SLVERR);
    rd(8'h30, 32'h0, `AGCR_RESP_SLVERR);
    fields;
    for (k = 0; k < 8; k++) begin
      d = $urandom;
      s = 4'h6 | (4'($urandom) & 4'h9);
      pre = (k < 4) ? k[1:0] : 2'h0;
      d[17:13] = {pre, k[2:0]};
      wr(`AGCR_CFG_ADDR, d, s, `AGCR_RESP_OKAY);
      cfg_q = merge(cfg_q, d, s);
      rd(`AGCR_CFG_ADDR, cfg_q, `AGCR_RESP_OKAY);
      fields;
      per(0, 1 << pre);
      per(1, (32 << k) << pre);
    end
    wr(`AGCR_CFG_ADDR, 32'h00380050, 4'h7, `AGCR_RESP_OKAY);
    phase(t);
    wr(`AGCR_CFG_ADDR, 32'h00b80050, 4'h7, `AGCR_RESP_OKAY);
    phase(k);
    chk("offdly", k, t);
    wr(`AGCR_CFG_ADDR, 32'h00780050, 4'h7, `AGCR_RESP_OKAY);
    phase(k);
    chk("gaindly", (k - t + 32) % 32, `AGCR_GAIN_DELAY);
    @(posedge clock);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    cfg_q = `AGCR_CFG_RESET;
    rd(`AGCR_CFG_ADDR, cfg_q, `AGCR_RESP_OKAY);
    fields;
    close_out;
  end
endmodule
